// *** logic/hpc_pkg.sv ***
// Purpose: Shared constants for the host port pin control block
// Assumes: APB register access, 32-bit data, pclk at 25 MHz
// Notes:   Register offsets here are byte addresses on the APB slave
package hpc_pkg;
    // Host-visible register selects
    localparam logic [1:0] SEL_CONTROL = 2'h0;
    localparam logic [1:0] SEL_ADDRESS = 2'h1;
    localparam logic [1:0] SEL_DATA    = 2'h2;
    localparam logic [1:0] SEL_DATA_AI = 2'h3;

    // APB register offsets
    localparam logic [7:0] OFF_CTRL    = 8'h00;
    localparam logic [7:0] OFF_STATUS  = 8'h04;
    localparam logic [7:0] OFF_IRQ_SET = 8'h08;
    localparam logic [7:0] OFF_ADDR    = 8'h0C;
    localparam logic [7:0] OFF_WDATA   = 8'h10;
    localparam logic [7:0] OFF_RDATA   = 8'h14;

    // Control register fields
    localparam int CTRL_READY_BIT = 0;
    localparam int CTRL_STRAP_BIT = 1;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

    // Host control register bit that clears the interrupt
    localparam int HOST_IRQ_BIT = 2;

    // Port access FSM
    typedef enum logic [1:0] {
        HPC_IDLE   = 2'b00,
        HPC_ACTIVE = 2'b01,
        HPC_DONE   = 2'b10
    } hpc_state_e;
endpackage : hpc_pkg

// *** logic/hpc_sync2.sv ***
// Purpose: Two-flop synchroniser for a bus of pin inputs
// Assumes: Inputs asynchronous to pclk
// Notes:   First stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module hpc_sync2 #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= INIT;
            q      <= INIT;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule // hpc_sync2
`default_nettype wire

// *** logic/hpc_buf2.sv ***
// Purpose: Two-entry buffer with valid/ready on both sides
// Assumes: Single clock
// Notes:   Full when two words held; no word lost on a stall
`timescale 1ns/1ps
`default_nettype none
module hpc_buf2 #(
    parameter int W = 16
) (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic      [W-1:0] out_data
);
    logic [W-1:0] mem_r [2];
    logic         rd_r;
    logic         wr_r;
    logic [1:0]   cnt_r;
    wire          push = in_valid && in_ready;
    wire          pop  = out_valid && out_ready;

    assign in_ready  = (cnt_r != 2'h2);
    assign out_valid = (cnt_r != 2'h0);
    assign out_data  = mem_r[rd_r];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_r  <= 1'b0;
            wr_r  <= 1'b0;
            cnt_r <= 2'h0;
        end else begin
            if (push) wr_r <= ~wr_r;
            if (pop) rd_r <= ~rd_r;
            cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
        end
    end

    always_ff @(posedge pclk) begin
        if (push) mem_r[wr_r] <= in_data;
    end
endmodule // hpc_buf2
`default_nettype wire

// *** logic/hpc_top.sv ***
// Purpose: Pin-level control of the parallel host port
// Assumes: Host pins are asynchronous and pass two flops first
// Notes:   Data bus pins drive only during host reads
// Functional notes
// - Register select chooses control, address or data
// - Register select honoured only in multiplexed mode
// - Pins act for host port when strap low
// - Global off floats all host port outputs
// - Address strobe captures address in multiplexed mode
// - Address strobe ignored in non-multiplexed mode
// - Data strobes time each port transfer
// - Direction input sets data bus direction
// - Ready output tells host next transfer allowed
// - Interrupt outputs low until host clears
// - Writing one to interrupt bit clears it
// - Interrupts only in multiplexed mode
// - Port reset resets port and both subsystems
// - Non-multiplexed mode: 18-bit address, 16-bit data
`timescale 1ns/1ps
`default_nettype none
module hpc_top #(
    parameter int AW = 18,
    parameter int DW = 16
) (
    // APB
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    // Host control pins
    input  wire logic          reg_select_bit0,
    input  wire logic          reg_select_bit1,
    input  wire logic          addr_strobe_n,
    input  wire logic          port_chip_select_n,
    input  wire logic          host_data_strobe_a_n,
    input  wire logic          host_data_strobe_b_n,
    input  wire logic          host_rd_wr_n,
    input  wire logic          mux_mode_select,
    input  wire logic          interface_select_strap,
    input  wire logic          global_off_n,
    input  wire logic          port_reset_n,
    // Host address and data pins
    input  wire logic [AW-1:0] host_addr_in,
    input  wire logic [DW-1:0] host_data_in,
    output logic      [DW-1:0] host_data_out,
    output logic               host_data_oe,
    // Host outputs with enables
    output logic               port_ready_out,
    output logic               port_ready_oe,
    output logic               host_irq_sub_a_n,
    output logic               host_irq_sub_b_n,
    output logic               host_irq_oe,
    // Subsystem side
    output logic               subsys_reset_n,
    output logic               host_port_active,
    output logic               host_ctrl_wr,
    output logic      [DW-1:0] host_ctrl_wdata
);
    localparam int NS = 11;

    // Synchronised pins
    logic [NS-1:0] pins_s;
    logic [AW-1:0] addr_s;
    logic [DW-1:0] data_s;
    hpc_sync2 #(.W(NS), .INIT(11'h7FC)) u_sync_ctl (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({port_reset_n, global_off_n, interface_select_strap, mux_mode_select,
                   host_rd_wr_n, host_data_strobe_b_n, host_data_strobe_a_n,
                   port_chip_select_n, addr_strobe_n, reg_select_bit1, reg_select_bit0}),
        .q       (pins_s)
    );
    hpc_sync2 #(.W(AW + DW)) u_sync_bus (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({host_addr_in, host_data_in}),
        .q       ({addr_s, data_s})
    );

    wire [1:0] sel_s    = pins_s[1:0];
    wire       as_n_s   = pins_s[2];
    wire       cs_n_s   = pins_s[3];
    wire       ds_a_s   = pins_s[4];
    wire       ds_b_s   = pins_s[5];
    wire       rw_s     = pins_s[6];
    wire       nonmux_s = pins_s[7];
    wire       strap_s  = pins_s[8];
    wire       off_n_s  = pins_s[9];
    wire       prst_n_s = pins_s[10];

    // Access FSM, address register and interrupts held in reset by either reset
    wire port_rst = !prst_n_s;
    assign subsys_reset_n = prst_n_s;

    wire host_mode = !strap_s;
    assign host_port_active = host_mode;

    // Strobe is the active combination of the two data strobes and chip select
    wire ds_act  = host_mode && !cs_n_s && (ds_a_s ^ ds_b_s) == 1'b0 && !ds_a_s;
    logic ds_act_d;
    wire ds_rise = ds_act && !ds_act_d;
    logic as_n_d;
    wire as_fall = host_mode && !nonmux_s && !as_n_s && as_n_d;

    // Latched per-access state
    hpc_pkg::hpc_state_e st_r;
    hpc_pkg::hpc_state_e st_nxt;
    logic [1:0]    sel_r;
    logic          rw_r;
    logic [AW-1:0] port_addr_r;
    logic          irq_a_r;
    logic          irq_b_r;
    logic [31:0]   ctrl_r;
    logic [DW-1:0] rdata_r;

    // In non-multiplexed mode only the data register is reachable
    wire [1:0] sel_eff = nonmux_s ? hpc_pkg::SEL_DATA : sel_s;

    // Buffer: host writes to data register flow to software
    logic          hw_valid;
    logic          hw_ready;
    logic          sw_valid;
    logic [DW-1:0] sw_data;
    wire           rd_pop;
    wire  data_sel = sel_r[1];
    assign hw_valid = (st_r == hpc_pkg::HPC_ACTIVE) && !rw_r && data_sel;

    hpc_buf2 #(.W(DW)) u_buf (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_valid  (hw_valid),
        .in_ready  (hw_ready),
        .in_data   (data_s),
        .out_valid (sw_valid),
        .out_ready (rd_pop),
        .out_data  (sw_data)
    );

    // APB decode
    wire acc      = psel && penable;
    wire wr_acc   = acc && pwrite;
    wire hit_ctrl = paddr == hpc_pkg::OFF_CTRL;
    wire hit_stat = paddr == hpc_pkg::OFF_STATUS;
    wire hit_irq  = paddr == hpc_pkg::OFF_IRQ_SET;
    wire hit_addr = paddr == hpc_pkg::OFF_ADDR;
    wire hit_wd   = paddr == hpc_pkg::OFF_WDATA;
    wire hit_rd   = paddr == hpc_pkg::OFF_RDATA;
    wire hit_any  = hit_ctrl | hit_stat | hit_irq | hit_addr | hit_wd | hit_rd;
    assign rd_pop  = acc && !pwrite && hit_rd;
    assign pready  = 1'b1;
    assign pslverr = acc && !hit_any;

    // Host control register write with interrupt-clear bit
    wire ctrl_wr = (st_r == hpc_pkg::HPC_ACTIVE) && !rw_r && sel_r == hpc_pkg::SEL_CONTROL;
    wire irq_clr = ctrl_wr && data_s[hpc_pkg::HOST_IRQ_BIT];
    wire irq_set_a = wr_acc && hit_irq && pwdata[0] && !nonmux_s;
    wire irq_set_b = wr_acc && hit_irq && pwdata[1] && !nonmux_s;

    // Access FSM: done waits for strobe release
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            hpc_pkg::HPC_IDLE:   if (ds_rise) st_nxt = hpc_pkg::HPC_ACTIVE;
            hpc_pkg::HPC_ACTIVE: if (rw_r || !data_sel || hw_ready) st_nxt = hpc_pkg::HPC_DONE;
            hpc_pkg::HPC_DONE:   if (!ds_act) st_nxt = hpc_pkg::HPC_IDLE;
            default:             st_nxt = hpc_pkg::HPC_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r     <= hpc_pkg::HPC_IDLE;
            ds_act_d <= 1'b0;
            as_n_d   <= 1'b1;
        end else if (port_rst) begin
            st_r     <= hpc_pkg::HPC_IDLE;
            ds_act_d <= 1'b0;
            as_n_d   <= 1'b1;
        end else begin
            st_r     <= st_nxt;
            ds_act_d <= ds_act;
            as_n_d   <= as_n_s;
        end
    end

    // Select and direction held for the whole access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_r <= 2'h0;
            rw_r  <= 1'b1;
        end else if (ds_rise && st_r == hpc_pkg::HPC_IDLE) begin
            sel_r <= sel_eff;
            rw_r  <= rw_s;
        end
    end

    // Address register: strobe in mux mode, pins in non-mux mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_addr_r <= '0;
        end else if (port_rst) begin
            port_addr_r <= '0;
        end else if (as_fall) begin
            port_addr_r <= {{(AW-DW){1'b0}}, data_s};
        end else if (ds_rise && nonmux_s) begin
            port_addr_r <= addr_s;
        end else if (ds_rise && sel_eff == hpc_pkg::SEL_ADDRESS && !rw_s) begin
            port_addr_r <= {{(AW-DW){1'b0}}, data_s};
        end
    end

    // Interrupts: set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_a_r <= 1'b0;
            irq_b_r <= 1'b0;
        end else if (port_rst || nonmux_s) begin
            irq_a_r <= 1'b0;
            irq_b_r <= 1'b0;
        end else begin
            irq_a_r <= irq_set_a | (irq_a_r & ~irq_clr);
            irq_b_r <= irq_set_b | (irq_b_r & ~irq_clr);
        end
    end

    // Software registers and host read data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r  <= hpc_pkg::CTRL_RESET;
            rdata_r <= '0;
        end else begin
            if (wr_acc && hit_ctrl) ctrl_r <= pwdata;
            if (wr_acc && hit_wd) rdata_r <= pwdata[DW-1:0];
        end
    end

    assign host_ctrl_wr    = ctrl_wr;
    assign host_ctrl_wdata = data_s;

    // Host read mux
    wire [DW-1:0] ctrl_view = {{(DW-3){1'b0}}, irq_a_r | irq_b_r, 2'b00};
    wire [DW-1:0] rd_mux = (sel_r == hpc_pkg::SEL_CONTROL) ? ctrl_view :
                           (sel_r == hpc_pkg::SEL_ADDRESS) ? port_addr_r[DW-1:0] : rdata_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            host_data_out <= '0;
        end else if (st_r == hpc_pkg::HPC_ACTIVE && rw_r) begin
            host_data_out <= rd_mux;
        end
    end

    // Pin drives; global off floats everything
    wire drive_ok = off_n_s && host_mode;
    wire ready_i  = (st_r == hpc_pkg::HPC_IDLE) && ctrl_r[hpc_pkg::CTRL_READY_BIT] && hw_ready;
    assign port_ready_out = ready_i;
    assign port_ready_oe  = drive_ok;
    assign host_irq_sub_a_n = !irq_a_r;
    assign host_irq_sub_b_n = !irq_b_r;
    assign host_irq_oe  = drive_ok && !nonmux_s;
    assign host_data_oe = drive_ok && st_r == hpc_pkg::HPC_DONE && rw_r;

    // APB read data
    wire [31:0] status_w = {12'h000, sw_valid, hw_ready, irq_b_r, irq_a_r,
                            12'h000, st_r, host_mode, nonmux_s};
    assign prdata = !(acc && !pwrite) ? 32'h0000_0000 :
                    hit_ctrl ? ctrl_r :
                    hit_stat ? status_w :
                    hit_addr ? {{(32-AW){1'b0}}, port_addr_r} :
                    hit_rd   ? {{(32-DW){1'b0}}, sw_data} :
                    hit_wd   ? {{(32-DW){1'b0}}, rdata_r} : 32'h0000_0000;

    a_irq_mux_only: assert property (@(posedge pclk) disable iff (!presetn)
        nonmux_s |=> !irq_a_r && !irq_b_r) else $error("irq set in non-mux mode");
    a_irq_clear: assert property (@(posedge pclk) disable iff (!presetn)
        irq_clr && !irq_set_a && !port_rst |=> !irq_a_r) else $error("irq not cleared");
    a_off_float: assert property (@(posedge pclk) disable iff (!presetn)
        !off_n_s |-> !port_ready_oe && !host_irq_oe && !host_data_oe) else $error("drive when off");
    a_strap_float: assert property (@(posedge pclk) disable iff (!presetn)
        strap_s |-> !port_ready_oe && !host_data_oe) else $error("drive in mem mode");
    a_ready_busy: assert property (@(posedge pclk) disable iff (!presetn)
        st_r != hpc_pkg::HPC_IDLE |-> !port_ready_out) else $error("ready while busy");
    a_latch_hold: assert property (@(posedge pclk) disable iff (!presetn)
        st_r == hpc_pkg::HPC_ACTIVE |=> $stable(sel_r) && $stable(rw_r)) else $error("select moved");
    a_as_ignored: assert property (@(posedge pclk) disable iff (!presetn)
        nonmux_s |-> !as_fall) else $error("strobe used in non-mux");
    a_port_reset: assert property (@(posedge pclk) disable iff (!presetn)
        port_rst |-> !subsys_reset_n ##1 st_r == hpc_pkg::HPC_IDLE) else $error("port reset");
endmodule // hpc_top
`default_nettype wire

// *** tb/hpc_host_model.sv ***
// Purpose: Host processor model that drives the port's control pins
// Assumes: Every pin changes just after a rising pclk edge
// Notes:   Data lines keep their last level, as the pin bus holders do
`timescale 1ns/1ps
`default_nettype none
module hpc_host_model (
    // Clock
    input  wire logic        pclk,
    // Device answers
    input  wire logic        ready,
    input  wire logic        data_oe,
    input  wire logic [15:0] data_wire,
    // Host drive
    output logic      [1:0]  sel,
    output logic             as_n,
    output logic             cs_n,
    output logic             ds_n,
    output logic             rd_wr_n,
    output logic      [17:0] addr,
    output logic      [15:0] data
);
    initial begin
        sel = 2'h0;
        as_n = 1'b1;
        cs_n = 1'b1;
        ds_n = 1'b1;
        rd_wr_n = 1'b1;
        addr = 18'h2AAAA;
        data = 16'h0000;
    end

    // A host never starts while ready is low; ok stays 0 if it does not come within 40 cycles
    task automatic wait_ready(output logic ok);
        int i;
        ok = 1'b0;
        for (i = 0; i < 40 && !ok; i++) begin
            @(posedge pclk);
            ok = (ready === 1'b1);
        end
    endtask

    task automatic xfer(input logic [1:0] s, input logic rd, input logic [15:0] wd,
                        output logic [15:0] rdat, output logic ok);
        int i;
        rdat = 16'h0000;
        wait_ready(ok);
        if (ok) begin
            cs_n <= 1'b0;
            sel <= s;
            rd_wr_n <= rd;
            data <= wd;
            @(posedge pclk);
            ds_n <= 1'b0;
            // Strobe spans pin sync, the active step and the done step
            for (i = 0; i < 6; i++) begin
                @(posedge pclk);
                if (data_oe === 1'b1)
                    rdat = data_wire;
            end
            ds_n <= 1'b1;
            @(posedge pclk);
            cs_n <= 1'b1;
        end
    endtask

    task automatic strobe_addr(input logic [15:0] a);
        data <= a;
        as_n <= 1'b0;
        repeat (4) @(posedge pclk);
        as_n <= 1'b1;
        repeat (4) @(posedge pclk);
    endtask
endmodule // hpc_host_model
`default_nettype wire

// *** tb/hpc_top_tb.sv ***
// Purpose: Self-checking bench for the host port pin control block
// Assumes: APB master and host model change pins just after a rising edge
// Notes:   Expected values come from the pin rules and package offsets
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_count++; \
    $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module hpc_top_tb;
    logic             pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic      [7:0]  paddr;
    logic      [31:0] pwdata, prdata, d;
    logic      [1:0]  sel;
    logic             as_n, cs_n, ds_n, rw_n, mode, strap, goff_n, prst_n, e, ok;
    logic             hoe, rdy, rdy_oe, irq_a_n, irq_b_n, irq_oe, sub_n, act, cwr;
    logic      [17:0] haddr;
    logic      [15:0] hdrv, hout, cwd, r;
    wire logic [15:0] hwire = (hoe === 1'b1) ? hout : hdrv;
    int               err_count = 0;
    int               n_checks = 0;
    int               n_ctrl = 0;
    int               c0;

    hpc_top dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .reg_select_bit0(sel[0]), .reg_select_bit1(sel[1]), .addr_strobe_n(as_n),
        .port_chip_select_n(cs_n), .host_data_strobe_a_n(ds_n), .host_data_strobe_b_n(ds_n),
        .host_rd_wr_n(rw_n), .mux_mode_select(mode), .interface_select_strap(strap),
        .global_off_n(goff_n), .port_reset_n(prst_n), .host_addr_in(haddr),
        .host_data_in(hwire), .host_data_out(hout), .host_data_oe(hoe),
        .port_ready_out(rdy), .port_ready_oe(rdy_oe), .host_irq_sub_a_n(irq_a_n),
        .host_irq_sub_b_n(irq_b_n), .host_irq_oe(irq_oe), .subsys_reset_n(sub_n),
        .host_port_active(act), .host_ctrl_wr(cwr), .host_ctrl_wdata(cwd));

    hpc_host_model host_u (
        .pclk(pclk), .ready(rdy), .data_oe(hoe), .data_wire(hwire), .sel(sel),
        .as_n(as_n), .cs_n(cs_n), .ds_n(ds_n), .rd_wr_n(rw_n), .addr(haddr), .data(hdrv));

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    always @(posedge pclk)
        if (cwr === 1'b1)
            n_ctrl++;

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic tdone(input string s);
        $display("test %s done, mismatches so far %0d", s, err_count);
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        int i;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        if (i == 16) begin
            err_count++;
            wrap_up();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {mode, strap, presetn} = 3'b000;
        {goff_n, prst_n} = 2'b11;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        apb(1'b0, hpc_pkg::OFF_CTRL, 32'h0, d, e);
        `CHK("ctrl reset", hpc_pkg::CTRL_RESET, d);
        `CHK("irq a idle", 1'b1, irq_a_n);
        `CHK("irq b idle", 1'b1, irq_b_n);
        `CHK("ready idle", 1'b1, rdy);
        apb(1'b0, 8'hFC, 32'h0, d, e);
        `CHK("unmapped err", 1'b1, e);
        apb(1'b0, hpc_pkg::OFF_STATUS, 32'h0, d, e);
        `CHK("status idle", 32'h00040002, d);
        tdone("reset");
        strap <= 1'b1;
        repeat (4) @(posedge pclk);
        `CHK("port active", 1'b0, act);
        `CHK("ready oe strap", 1'b0, rdy_oe);
        strap <= 1'b0;
        goff_n <= 1'b0;
        repeat (4) @(posedge pclk);
        `CHK("ready oe off", 1'b0, rdy_oe);
        `CHK("irq oe off", 1'b0, irq_oe);
        goff_n <= 1'b1;
        repeat (4) @(posedge pclk);
        `CHK("irq oe mux", 1'b1, irq_oe);
        tdone("pins");
        host_u.strobe_addr(16'hA5C3);
        apb(1'b0, hpc_pkg::OFF_ADDR, 32'h0, d, e);
        `CHK("addr capture", 32'h0000A5C3, d);
        mode <= 1'b1;
        repeat (4) @(posedge pclk);
        host_u.strobe_addr(16'h1234);
        apb(1'b0, hpc_pkg::OFF_ADDR, 32'h0, d, e);
        `CHK("addr nonmux", 32'h0000A5C3, d);
        c0 = n_ctrl;
        host_u.xfer(hpc_pkg::SEL_CONTROL, 1'b0, 16'h0077, r, ok);
        `CHK("nonmux ok", 1'b1, ok);
        `CHK("sel ignored", c0, n_ctrl);
        apb(1'b0, hpc_pkg::OFF_RDATA, 32'h0, d, e);
        `CHK("forced data", 32'h00000077, d);
        apb(1'b1, hpc_pkg::OFF_IRQ_SET, 32'h3, d, e);
        repeat (2) @(posedge pclk);
        `CHK("irq oe nonmux", 1'b0, irq_oe);
        mode <= 1'b0;
        repeat (4) @(posedge pclk);
        tdone("address");
        host_u.xfer(hpc_pkg::SEL_DATA, 1'b0, 16'h1111, r, ok);
        `CHK("wr1 ok", 1'b1, ok);
        host_u.xfer(hpc_pkg::SEL_DATA, 1'b0, 16'h2222, r, ok);
        `CHK("wr2 ok", 1'b1, ok);
        repeat (4) @(posedge pclk);
        `CHK("ready full", 1'b0, rdy);
        host_u.xfer(hpc_pkg::SEL_DATA, 1'b0, 16'h3333, r, ok);
        `CHK("wr3 held", 1'b0, ok);
        apb(1'b0, hpc_pkg::OFF_RDATA, 32'h0, d, e);
        `CHK("pop1", 32'h00001111, d);
        host_u.xfer(hpc_pkg::SEL_DATA, 1'b0, 16'h3333, r, ok);
        `CHK("wr3 ok", 1'b1, ok);
        apb(1'b0, hpc_pkg::OFF_RDATA, 32'h0, d, e);
        `CHK("pop2", 32'h00002222, d);
        apb(1'b0, hpc_pkg::OFF_RDATA, 32'h0, d, e);
        `CHK("pop3", 32'h00003333, d);
        apb(1'b1, hpc_pkg::OFF_WDATA, 32'h0000BEEF, d, e);
        host_u.xfer(hpc_pkg::SEL_DATA, 1'b1, 16'h0000, r, ok);
        `CHK("host read", 16'hBEEF, r);
        tdone("data");
        apb(1'b1, hpc_pkg::OFF_IRQ_SET, 32'h3, d, e);
        repeat (12) @(posedge pclk);
        `CHK("irq a held", 1'b0, irq_a_n);
        `CHK("irq b held", 1'b0, irq_b_n);
        c0 = n_ctrl;
        host_u.xfer(hpc_pkg::SEL_CONTROL, 1'b0, 16'h0005, r, ok);
        `CHK("ctrl write", c0 + 1, n_ctrl);
        `CHK("ctrl data", 16'h0005, cwd);
        `CHK("irq a clear", 1'b1, irq_a_n);
        `CHK("irq b clear", 1'b1, irq_b_n);
        apb(1'b1, hpc_pkg::OFF_CTRL, 32'h0, d, e);
        repeat (2) @(posedge pclk);
        `CHK("ready off", 1'b0, rdy);
        apb(1'b1, hpc_pkg::OFF_CTRL, 32'h1, d, e);
        repeat (2) @(posedge pclk);
        `CHK("ready on", 1'b1, rdy);
        tdone("interrupt");
        apb(1'b1, hpc_pkg::OFF_IRQ_SET, 32'h3, d, e);
        prst_n <= 1'b0;
        repeat (4) @(posedge pclk);
        `CHK("subsys reset", 1'b0, sub_n);
        `CHK("irq a reset", 1'b1, irq_a_n);
        prst_n <= 1'b1;
        repeat (4) @(posedge pclk);
        `CHK("subsys run", 1'b1, sub_n);
        tdone("port reset");
        wrap_up();
    end
endmodule // hpc_top_tb
`undef CHK
`default_nettype wire
